// ### core/cds_pkg.sv
package cds_pkg;
   // register addresses on the serial port
   localparam logic [7:0] DC_THERMAL_DETAIL_STATUS_ADDR      = 8'h03;
   localparam logic [7:0] BATTERY_CHARGER_DETAIL_STATUS_ADDR = 8'h04;
   localparam logic [7:0] UNMAPPED_READ_VALUE                = 8'h00;
   localparam logic [7:0] DETAIL_CLEAR_VALUE                 = 8'h00;
   localparam logic [6:0] DEFAULT_SLAVE_ADDR                 = 7'h6A;

   // dc_thermal_detail_status fields
   localparam int INPUT_VOLTAGE_INVALID_BIT = 7;
   localparam int INPUT_CURRENT_LIMITED_BIT = 6;
   localparam int INPUT_OVERVOLTAGE_BIT     = 5;
   localparam int INPUT_ABOVE_BATTERY_BIT   = 4;
   localparam int RESERVED_BIT              = 3;
   localparam int THERMISTOR_ZONE_LSB       = 0;

   // battery_charger_detail_status fields
   localparam int BATTERY_CONDITION_LSB     = 4;
   localparam int CHARGER_STATE_LSB         = 0;

   // thermistor zone codes
   localparam logic [2:0] THM_COLD   = 3'h1;
   localparam logic [2:0] THM_COOL   = 3'h2;
   localparam logic [2:0] THM_NORMAL = 3'h3;
   localparam logic [2:0] THM_WARM   = 3'h4;
   localparam logic [2:0] THM_HOT    = 3'h5;

   // battery condition codes
   localparam logic [1:0] BAT_DEAD        = 2'h0;
   localparam logic [1:0] BAT_TIMER_FAULT = 2'h1;
   localparam logic [1:0] BAT_GOOD        = 2'h2;
   localparam logic [1:0] BAT_OVERVOLTAGE = 2'h3;

   // charger state codes
   localparam logic [3:0] CHG_DEAD_BATTERY = 4'h0;
   localparam logic [3:0] CHG_PREQUAL      = 4'h1;
   localparam logic [3:0] CHG_FAST_CC      = 4'h2;
   localparam logic [3:0] CHG_FAST_CV      = 4'h3;
   localparam logic [3:0] CHG_TOPOFF       = 4'h4;
   localparam logic [3:0] CHG_DONE         = 4'h5;
   localparam logic [3:0] CHG_TIMER_FAULT  = 4'h6;
   localparam logic [3:0] CHG_TEMP_SUSPEND = 4'h7;
   localparam logic [3:0] CHG_OFF          = 4'h8;
   localparam logic [3:0] CHG_THERMAL_LOOP = 4'h9;

   // serial bit counter limit
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // positions in the synchronised input vector
   localparam int SYNC_WIDTH        = 23;
   localparam int SY_SCL            = 0;
   localparam int SY_SDA            = 1;
   localparam int SY_DC_INVALID     = 2;
   localparam int SY_DC_LIMITED     = 3;
   localparam int SY_DC_OVERVOLTAGE = 4;
   localparam int SY_DC_ABOVE_BAT   = 5;
   localparam int SY_THM_BELOW_0    = 6;
   localparam int SY_THM_BELOW_15   = 7;
   localparam int SY_THM_BELOW_45   = 8;
   localparam int SY_THM_BELOW_60   = 9;
   localparam int SY_BAT_DEAD       = 10;
   localparam int SY_TIMER_FAULT    = 11;
   localparam int SY_BAT_OVERVOLT   = 12;
   localparam int SY_CHG_ENABLED    = 13;
   localparam int SY_PREQUAL        = 14;
   localparam int SY_FAST_CC        = 15;
   localparam int SY_FAST_CV        = 16;
   localparam int SY_TOPOFF         = 17;
   localparam int SY_DONE           = 18;
   localparam int SY_THERMAL_LOOP   = 19;
   localparam int SY_STANDBY_VALID  = 20;
   localparam int SY_SAFE_OUT_GOOD  = 21;
   localparam int SY_SPARE          = 22;

   typedef enum logic [3:0] {
      SER_IDLE,
      SER_ADDR,
      SER_ADDR_ACK,
      SER_PTR,
      SER_PTR_ACK,
      SER_WDATA,
      SER_WDATA_ACK,
      SER_RDATA,
      SER_RDATA_ACK,
      SER_RDATA_LOAD
   } cds_serial_e;
endpackage

// ### core/cds_sync.sv
`timescale 1ns/1ps
module cds_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clock,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);
   initial begin
      if (WIDTH < 1) begin
         $error("cds_sync: WIDTH must be at least 1");
      end
   end

   // two flops per bit, first stage feeds only the second
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      logic stage1_r;
      always_ff @(posedge clock or posedge reset) begin
         if (reset) begin
            stage1_r   <= 1'b0;
            syncOut[i] <= 1'b0;
         end else begin
            stage1_r   <= asyncIn[i];
            syncOut[i] <= stage1_r;
         end
      end
   end
endmodule

// ### core/cds_detail_status.sv
`timescale 1ns/1ps
module cds_detail_status
   import cds_pkg::*;
#(
   parameter logic [6:0] SLAVE_ADDR = DEFAULT_SLAVE_ADDR
) (
   input  wire logic clock,
   input  wire logic reset,
   input  wire logic sclIn,
   input  wire logic sdaIn,
   output logic      sdaOut,
   output logic      sdaOe,
   input  wire logic dcInvalid,
   input  wire logic dcCurrentLimited,
   input  wire logic dcOvervoltage,
   input  wire logic dcAboveBattery,
   input  wire logic thmBelow0,
   input  wire logic thmBelow15,
   input  wire logic thmBelow45,
   input  wire logic thmBelow60,
   input  wire logic batBelowDead,
   input  wire logic timerFault,
   input  wire logic batAboveOvervoltage,
   input  wire logic chargerEnabled,
   input  wire logic phasePrequal,
   input  wire logic phaseFastCc,
   input  wire logic phaseFastCv,
   input  wire logic phaseTopoff,
   input  wire logic phaseDone,
   input  wire logic thermalLoopActive,
   input  wire logic standbySupplyValid,
   input  wire logic safeOutputPowerGood,
   output logic      chargerSummaryFlag,
   output logic      batterySummaryFlag,
   output logic      thermistorSummaryFlag
);
   initial begin
      if (SLAVE_ADDR == 7'h00) begin
         $error("cds_detail_status: general call address not allowed");
      end
   end

   logic [SYNC_WIDTH-1:0] rawIn;
   logic [SYNC_WIDTH-1:0] syncIn;
   logic                  sclS;
   logic                  sdaS;
   logic                  sclD_r;
   logic                  sdaD_r;
   logic                  sclRise;
   logic                  sclFall;
   logic                  startSeen;
   logic                  stopSeen;
   logic                  powerGoodD_r;
   logic                  clearDetails;
   logic [2:0]            thmCode_nxt;
   logic [1:0]            batCode_nxt;
   logic [3:0]            chgCode_nxt;
   logic [7:0]            detail1_nxt;
   logic [7:0]            detail2_nxt;
   logic [7:0]            detail1_r;
   logic [7:0]            detail2_r;
   logic                  dcValid;
   logic                  tempSuspend;
   logic [7:0]            readByte;
   cds_serial_e           state_r;
   logic [3:0]            bitCnt_r;
   logic [7:0]            shift_r;
   logic [7:0]            pointer_r;
   logic                  readMode_r;

   assign rawIn = {1'b0, safeOutputPowerGood, standbySupplyValid, thermalLoopActive, phaseDone,
                   phaseTopoff, phaseFastCv, phaseFastCc, phasePrequal, chargerEnabled,
                   batAboveOvervoltage, timerFault, batBelowDead, thmBelow60, thmBelow45,
                   thmBelow15, thmBelow0, dcAboveBattery, dcOvervoltage, dcCurrentLimited,
                   dcInvalid, sdaIn, sclIn};

   cds_sync #(
      .WIDTH   (SYNC_WIDTH)
   ) u_sync (
      .clock   (clock),
      .reset   (reset),
      .asyncIn (rawIn),
      .syncOut (syncIn)
   );

   assign sclS      = syncIn[SY_SCL];
   assign sdaS      = syncIn[SY_SDA];
   assign dcValid   = ~syncIn[SY_DC_INVALID];

   // delayed copies for edge detection
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sclD_r       <= 1'b1;
         sdaD_r       <= 1'b1;
         powerGoodD_r <= 1'b0;
      end else begin
         sclD_r       <= sclS;
         sdaD_r       <= sdaS;
         powerGoodD_r <= syncIn[SY_SAFE_OUT_GOOD];
      end
   end

   assign sclRise      = sclS & ~sclD_r;
   assign sclFall      = ~sclS & sclD_r;
   assign startSeen    = sclS & sclD_r & sdaD_r & ~sdaS;
   assign stopSeen     = sclS & sclD_r & ~sdaD_r & sdaS;
   assign clearDetails = ~syncIn[SY_STANDBY_VALID] | (syncIn[SY_SAFE_OUT_GOOD] & ~powerGoodD_r);

   // thermistor zone from the threshold comparators
   always_comb begin
      if (syncIn[SY_THM_BELOW_0]) begin
         thmCode_nxt = THM_COLD;
      end else if (syncIn[SY_THM_BELOW_15]) begin
         thmCode_nxt = THM_COOL;
      end else if (syncIn[SY_THM_BELOW_45]) begin
         thmCode_nxt = THM_NORMAL;
      end else if (syncIn[SY_THM_BELOW_60]) begin
         thmCode_nxt = THM_WARM;
      end else begin
         thmCode_nxt = THM_HOT;
      end
   end

   assign tempSuspend = (thmCode_nxt == THM_COLD) | (thmCode_nxt == THM_HOT);

   // battery condition
   always_comb begin
      if (syncIn[SY_BAT_DEAD]) begin
         batCode_nxt = BAT_DEAD;
      end else if (syncIn[SY_TIMER_FAULT]) begin
         batCode_nxt = BAT_TIMER_FAULT;
      end else if (syncIn[SY_BAT_OVERVOLT] && dcValid) begin
         batCode_nxt = BAT_OVERVOLTAGE;
      end else begin
         batCode_nxt = BAT_GOOD;
      end
   end

   // charger state, highest priority first
   always_comb begin
      if (!dcValid || !syncIn[SY_CHG_ENABLED]) begin
         chgCode_nxt = CHG_OFF;
      end else if (syncIn[SY_BAT_DEAD]) begin
         chgCode_nxt = CHG_DEAD_BATTERY;
      end else if (syncIn[SY_TIMER_FAULT]) begin
         chgCode_nxt = CHG_TIMER_FAULT;
      end else if (tempSuspend) begin
         chgCode_nxt = CHG_TEMP_SUSPEND;
      end else if (syncIn[SY_DONE]) begin
         chgCode_nxt = CHG_DONE;
      end else if (syncIn[SY_THERMAL_LOOP] && (syncIn[SY_PREQUAL] || syncIn[SY_FAST_CC] ||
                                               syncIn[SY_FAST_CV] || syncIn[SY_TOPOFF])) begin
         chgCode_nxt = CHG_THERMAL_LOOP;
      end else if (syncIn[SY_PREQUAL]) begin
         chgCode_nxt = CHG_PREQUAL;
      end else if (syncIn[SY_FAST_CV]) begin
         chgCode_nxt = CHG_FAST_CV;
      end else if (syncIn[SY_FAST_CC]) begin
         chgCode_nxt = CHG_FAST_CC;
      end else if (syncIn[SY_TOPOFF]) begin
         chgCode_nxt = CHG_TOPOFF;
      end else begin
         chgCode_nxt = CHG_OFF;
      end
   end

   // register images
   always_comb begin
      detail1_nxt                            = DETAIL_CLEAR_VALUE;
      detail2_nxt                            = DETAIL_CLEAR_VALUE;
      if (!clearDetails) begin
         detail1_nxt[INPUT_VOLTAGE_INVALID_BIT] = syncIn[SY_DC_INVALID];
         detail1_nxt[INPUT_CURRENT_LIMITED_BIT] = syncIn[SY_DC_LIMITED];
         detail1_nxt[INPUT_OVERVOLTAGE_BIT]     = syncIn[SY_DC_OVERVOLTAGE];
         detail1_nxt[INPUT_ABOVE_BATTERY_BIT]   = syncIn[SY_DC_ABOVE_BAT];
         detail1_nxt[RESERVED_BIT]              = 1'b0;
         detail1_nxt[THERMISTOR_ZONE_LSB +: 3]  = thmCode_nxt;
         detail2_nxt[BATTERY_CONDITION_LSB +: 2] = batCode_nxt;
         detail2_nxt[CHARGER_STATE_LSB +: 4]    = chgCode_nxt;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         detail1_r <= DETAIL_CLEAR_VALUE;
         detail2_r <= DETAIL_CLEAR_VALUE;
      end else begin
         detail1_r <= detail1_nxt;
         detail2_r <= detail2_nxt;
      end
   end

   // summary flags track the images in the same cycle
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         chargerSummaryFlag    <= 1'b0;
         batterySummaryFlag    <= 1'b0;
         thermistorSummaryFlag <= 1'b1;
      end else begin
         chargerSummaryFlag    <= (detail2_nxt[CHARGER_STATE_LSB +: 4] == CHG_DONE) ||
                                  (detail2_nxt[CHARGER_STATE_LSB +: 4] == CHG_TIMER_FAULT) ||
                                  (detail2_nxt[CHARGER_STATE_LSB +: 4] == CHG_TEMP_SUSPEND) ||
                                  (detail2_nxt[CHARGER_STATE_LSB +: 4] == CHG_OFF);
         batterySummaryFlag    <= (detail2_nxt[BATTERY_CONDITION_LSB +: 2] == BAT_TIMER_FAULT) ||
                                  (detail2_nxt[BATTERY_CONDITION_LSB +: 2] == BAT_OVERVOLTAGE);
         thermistorSummaryFlag <= (detail1_nxt[THERMISTOR_ZONE_LSB +: 3] != THM_WARM) &&
                                  (detail1_nxt[THERMISTOR_ZONE_LSB +: 3] != THM_HOT);
      end
   end

   // read mux, no side effects
   always_comb begin
      unique case (pointer_r)
         DC_THERMAL_DETAIL_STATUS_ADDR:      readByte = detail1_r;
         BATTERY_CHARGER_DETAIL_STATUS_ADDR: readByte = detail2_r;
         default:                            readByte = UNMAPPED_READ_VALUE;
      endcase
   end

   // open-drain data line only ever pulls low
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sdaOut <= 1'b0;
      end else begin
         sdaOut <= 1'b0;
      end
   end

   // serial slave
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_r    <= SER_IDLE;
         bitCnt_r   <= 4'h0;
         shift_r    <= 8'h00;
         pointer_r  <= 8'h00;
         readMode_r <= 1'b0;
         sdaOe      <= 1'b0;
      end else if (startSeen) begin
         state_r  <= SER_ADDR;
         bitCnt_r <= 4'h0;
         sdaOe    <= 1'b0;
      end else if (stopSeen) begin
         state_r <= SER_IDLE;
         sdaOe   <= 1'b0;
      end else begin
         unique case (state_r)
            SER_IDLE: begin
               sdaOe <= 1'b0;
            end
            SER_ADDR, SER_PTR, SER_WDATA: begin
               if (sclRise && bitCnt_r != BITS_PER_BYTE) begin
                  shift_r  <= {shift_r[6:0], sdaS};
                  bitCnt_r <= bitCnt_r + 4'h1;
               end else if (sclFall && bitCnt_r == BITS_PER_BYTE) begin
                  bitCnt_r <= 4'h0;
                  if (state_r == SER_ADDR) begin
                     if (shift_r[7:1] == SLAVE_ADDR) begin
                        readMode_r <= shift_r[0];
                        sdaOe      <= 1'b1;
                        state_r    <= SER_ADDR_ACK;
                     end else begin
                        state_r <= SER_IDLE;
                     end
                  end else if (state_r == SER_PTR) begin
                     pointer_r <= shift_r;
                     sdaOe     <= 1'b1;
                     state_r   <= SER_PTR_ACK;
                  end else begin
                     sdaOe   <= 1'b1;
                     state_r <= SER_WDATA_ACK;
                  end
               end
            end
            SER_ADDR_ACK, SER_RDATA_LOAD: begin
               if (sclFall) begin
                  if (readMode_r) begin
                     sdaOe    <= ~readByte[7];
                     shift_r  <= {readByte[6:0], 1'b0};
                     bitCnt_r <= 4'h1;
                     state_r  <= SER_RDATA;
                  end else begin
                     sdaOe    <= 1'b0;
                     bitCnt_r <= 4'h0;
                     state_r  <= SER_PTR;
                  end
               end
            end
            SER_PTR_ACK, SER_WDATA_ACK: begin
               if (sclFall) begin
                  sdaOe    <= 1'b0;
                  bitCnt_r <= 4'h0;
                  state_r  <= SER_WDATA;
               end
            end
            SER_RDATA: begin
               if (sclFall) begin
                  if (bitCnt_r == BITS_PER_BYTE) begin
                     sdaOe     <= 1'b0;
                     pointer_r <= pointer_r + 8'h01;
                     state_r   <= SER_RDATA_ACK;
                  end else begin
                     sdaOe    <= ~shift_r[7];
                     shift_r  <= {shift_r[6:0], 1'b0};
                     bitCnt_r <= bitCnt_r + 4'h1;
                  end
               end
            end
            SER_RDATA_ACK: begin
               if (sclRise) begin
                  state_r <= sdaS ? SER_IDLE : SER_RDATA_LOAD;
               end
            end
         endcase
      end
   end
endmodule

// ### verification/cds_detail_status_chk.sv
`timescale 1ns/1ps
module cds_detail_status_chk (
   input  wire logic clock,
   input  wire logic reset,
   input  wire logic dcInvalid,
   input  wire logic thmBelow15,
   input  wire logic thmBelow45,
   input  wire logic thmBelow60,
   input  wire logic batBelowDead,
   input  wire logic timerFault,
   input  wire logic batAboveOvervoltage,
   input  wire logic chargerEnabled,
   input  wire logic phaseFastCc,
   input  wire logic phaseDone,
   input  wire logic standbySupplyValid,
   input  wire logic safeOutputPowerGood,
   input  wire logic chargerSummaryFlag,
   input  wire logic batterySummaryFlag,
   input  wire logic thermistorSummaryFlag
);
   logic pgPrev_r;
   logic quiet;
   logic live;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pgPrev_r <= 1'b0;
      end else begin
         pgPrev_r <= safeOutputPowerGood;
      end
   end
   assign quiet = standbySupplyValid && !(safeOutputPowerGood && !pgPrev_r);
   assign live  = quiet && !dcInvalid && chargerEnabled && !batBelowDead && !timerFault;
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   // condition held long enough to cross the synchronisers
   sequence sqSettled(c);
      c[*5];
   endsequence
   AST_OFF: assert property (sqSettled(quiet && dcInvalid) |=> chargerSummaryFlag)
      else $error("charger flag low while off");
   AST_DEAD: assert property (sqSettled(quiet && !dcInvalid && chargerEnabled && batBelowDead)
      |=> !chargerSummaryFlag && !batterySummaryFlag) else $error("dead battery flags wrong");
   AST_TIMER: assert property (sqSettled(quiet && !dcInvalid && chargerEnabled && !batBelowDead && timerFault)
      |=> chargerSummaryFlag && batterySummaryFlag) else $error("timer fault flags wrong");
   AST_OVERVOLT: assert property (sqSettled(live && batAboveOvervoltage) |=> batterySummaryFlag)
      else $error("overvoltage not flagged");
   AST_OV_GATED: assert property (sqSettled(quiet && dcInvalid && !batBelowDead && !timerFault
      && batAboveOvervoltage) |=> !batterySummaryFlag) else $error("overvoltage flagged without input");
   AST_HOT: assert property (sqSettled(live && !thmBelow60)
      |=> chargerSummaryFlag && !thermistorSummaryFlag) else $error("hot zone flags wrong");
   AST_WARM: assert property (sqSettled(quiet && thmBelow60 && !thmBelow45) |=> !thermistorSummaryFlag)
      else $error("warm zone flag wrong");
   AST_FAST: assert property (sqSettled(live && thmBelow45 && !thmBelow15 && phaseFastCc && !phaseDone)
      |=> !chargerSummaryFlag && thermistorSummaryFlag) else $error("charging flags wrong");
   AST_DONE: assert property (sqSettled(live && thmBelow45 && !thmBelow15 && phaseDone) |=> chargerSummaryFlag)
      else $error("done not flagged");
   AST_CLEAR: assert property (sqSettled(!standbySupplyValid)
      |=> !chargerSummaryFlag && !batterySummaryFlag && thermistorSummaryFlag) else $error("clear flags wrong");
endmodule

bind cds_detail_status cds_detail_status_chk i_chk (
   .clock(clock), .reset(reset), .dcInvalid(dcInvalid), .thmBelow15(thmBelow15), .thmBelow45(thmBelow45),
   .thmBelow60(thmBelow60), .batBelowDead(batBelowDead), .timerFault(timerFault),
   .batAboveOvervoltage(batAboveOvervoltage), .chargerEnabled(chargerEnabled), .phaseFastCc(phaseFastCc),
   .phaseDone(phaseDone), .standbySupplyValid(standbySupplyValid), .safeOutputPowerGood(safeOutputPowerGood),
   .chargerSummaryFlag(chargerSummaryFlag), .batterySummaryFlag(batterySummaryFlag),
   .thermistorSummaryFlag(thermistorSummaryFlag));

// ### verification/cds_host_model.sv
`timescale 1ns/1ps
module cds_host_model (
   input  wire logic clock,
   input  wire logic sdaOe,
   output logic      sclIn,
   output logic      sdaIn
);
   logic sclLine = 1'b1;
   logic hostLow = 1'b0;
   // open-drain data line with pull-up
   assign sdaIn = !(hostLow || sdaOe);
   assign sclIn = sclLine;
   task automatic hw();
      repeat (6) @(posedge clock);
   endtask
   task automatic bitx(input logic b, output logic s);
      hostLow <= !b;
      hw();
      sclLine <= 1'b1;
      hw();
      s = sdaIn;
      sclLine <= 1'b0;
      hw();
   endtask
   task automatic start();
      hostLow <= 1'b0;
      hw();
      sclLine <= 1'b1;
      hw();
      hostLow <= 1'b1;
      hw();
      sclLine <= 1'b0;
      hw();
   endtask
   task automatic stop();
      hostLow <= 1'b1;
      hw();
      sclLine <= 1'b1;
      hw();
      hostLow <= 1'b0;
      hw();
   endtask
   task automatic byteOut(input logic [7:0] d, output logic ok);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitx(d[i], s);
      end
      bitx(1'b1, s);
      ok = !s;
   endtask
   task automatic byteIn(input logic nack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitx(1'b1, s);
         d[i] = s;
      end
      bitx(nack, s);
   endtask
   task automatic readPair(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d0,
                           output logic [7:0] d1, output logic ok);
      logic k1;
      logic k2;
      logic k3;
      start();
      byteOut({a, 1'b0}, k1);
      byteOut(p, k2);
      start();
      byteOut({a, 1'b1}, k3);
      byteIn(1'b0, d0);
      byteIn(1'b1, d1);
      stop();
      ok = k1 && k2 && k3;
   endtask
   task automatic writeReg(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d);
      logic k;
      start();
      byteOut({a, 1'b0}, k);
      byteOut(p, k);
      byteOut(d, k);
      stop();
   endtask
endmodule

// ### verification/cds_detail_status_bench.sv
`timescale 1ns/1ps
module cds_detail_status_bench
   import cds_pkg::*;
;
   logic        clock = 1'b0;
   logic        reset = 1'b1;
   logic        standby = 1'b0;
   logic [17:0] c = '0;
   logic        sclIn;
   logic        sdaIn;
   logic        sdaOe;
   logic        sdaOutPin;
   logic        chgFlag;
   logic        batFlag;
   logic        thmFlag;
   int          err_total = 0;
   int          check_count = 0;
   integer      seed = 11425;
   logic [31:0] r;
   logic [17:0] v;
   logic [7:0]  p;
   logic [7:0]  d0;
   logic [7:0]  d1;
   logic        ok;
   logic [7:0]  dcExp;
   logic [7:0]  bcExp;
   always #25 clock = ~clock;
   cds_detail_status i_dut (.clock(clock), .reset(reset), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOutPin),
      .sdaOe(sdaOe),
      .dcInvalid(c[0]), .dcCurrentLimited(c[1]), .dcOvervoltage(c[2]), .dcAboveBattery(c[3]),
      .thmBelow0(c[4]), .thmBelow15(c[5]), .thmBelow45(c[6]), .thmBelow60(c[7]), .batBelowDead(c[8]),
      .timerFault(c[9]), .batAboveOvervoltage(c[10]), .chargerEnabled(c[11]), .phasePrequal(c[12]),
      .phaseFastCc(c[13]), .phaseFastCv(c[14]), .phaseTopoff(c[15]), .phaseDone(c[16]),
      .thermalLoopActive(c[17]), .standbySupplyValid(standby), .safeOutputPowerGood(1'b0),
      .chargerSummaryFlag(chgFlag), .batterySummaryFlag(batFlag), .thermistorSummaryFlag(thmFlag));
   cds_host_model i_host (.clock(clock), .sdaOe(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn));
   function automatic logic [2:0] zoneOf(logic [17:0] x);
      return !x[7] ? 3'h5 : !x[6] ? 3'h4 : !x[5] ? 3'h3 : !x[4] ? 3'h2 : 3'h1;
   endfunction
   function automatic logic [1:0] batOf(logic [17:0] x);
      return x[8] ? 2'h0 : x[9] ? 2'h1 : (x[10] && !x[0]) ? 2'h3 : 2'h2;
   endfunction
   function automatic logic [3:0] chgOf(logic [17:0] x);
      if (x[0] || !x[11]) return 4'h8;
      if (x[8]) return 4'h0;
      if (x[9]) return 4'h6;
      if (zoneOf(x) inside {3'h1, 3'h5}) return 4'h7;
      if (x[16]) return 4'h5;
      if (x[17] && |x[15:12]) return 4'h9;
      if (x[12]) return 4'h1;
      if (x[14]) return 4'h3;
      if (x[13]) return 4'h2;
      if (x[15]) return 4'h4;
      return 4'h8;
   endfunction
   // first ten passes force every charger state, the rest are random except the thermistor zone, which cycles with i % 5
   function automatic logic [17:0] mk(int i, logic [17:0] x);
      int z;
      z = i % 5 + 1;
      if (i < 10) begin
         x[0] = (i == 8);
         x[11] = 1'b1;
         x[10:8] = {(i == 2 || i == 8), 2'b00};
         x[17:12] = '0;
         z = (i == 7) ? 5 : 3;
         x[8] = (i == 0);
         x[9] = (i == 6);
         if (i >= 1 && i <= 5) x[11 + i] = 1'b1;
         if (i == 9) {x[17], x[13]} = 2'b11;
      end
      x[7:4] = {z <= 4, z <= 3, z <= 2, z == 1};
      return x;
   endfunction
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      check_count++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", n, e, g);
         err_total++;
      end
   endtask
   task automatic results();
      if (err_total == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clock);
      err_total++;
      results();
   end
   initial begin
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      repeat (6) @(posedge clock);
      i_host.readPair(DEFAULT_SLAVE_ADDR, 8'h03, d0, d1, ok);
      chk("clearDc", 8'h00, d0);
      chk("clearBc", 8'h00, d1);
      standby <= 1'b1;
      for (int i = 0; i < 20; i++) begin
         r = $random(seed);
         v = mk(i, r[17:0]);
         c <= v;
         p = (i % 2) ? 8'h04 : 8'h03;
         dcExp = {v[0], v[1], v[2], v[3], 1'b0, zoneOf(v)};
         bcExp = {2'b00, batOf(v), chgOf(v)};
         repeat (6) @(posedge clock);
         chk("chgFlag", {7'h00, bcExp[3:0] inside {4'h5, 4'h6, 4'h7, 4'h8}}, {7'h00, chgFlag});
         chk("batFlag", {7'h00, bcExp[4]}, {7'h00, batFlag});
         chk("thmFlag", {7'h00, !(dcExp[2:0] inside {3'h4, 3'h5})}, {7'h00, thmFlag});
         chk("sdaOut", 8'h00, {7'h00, sdaOutPin});
         if (i % 3 == 1) i_host.writeReg(DEFAULT_SLAVE_ADDR, p, r[31:24]);
         i_host.readPair(DEFAULT_SLAVE_ADDR, p, d0, d1, ok);
         chk("ack", 8'h01, {7'h00, ok});
         chk("first", (p == 8'h03) ? dcExp : bcExp, d0);
         chk("second", (p == 8'h03) ? bcExp : 8'h00, d1);
      end
      i_host.readPair(DEFAULT_SLAVE_ADDR ^ 7'h01, 8'h03, d0, d1, ok);
      chk("otherAck", 8'h00, {7'h00, ok});
      chk("otherData", 8'hFF, d0);
      results();
   end
endmodule
